//--- src/pll_ctrl_pkg.sv
// Purpose: Shared constants and types for the loop control and base clock selector
// Assumes: 32-bit APB, byte address equals four times the register index
// Notes: Tolerances are counts of feedback edges per measurement window
`default_nettype none
package pll_ctrl_pkg;
   // Register indices and byte addresses
   localparam logic [7:0] IDX_LOOP_CTRL = 8'h1C;
   localparam logic [7:0] IDX_BW_CTRL = 8'h1D;
   localparam logic [7:0] IDX_MULT = 8'h1E;
   localparam logic [7:0] IDX_TOL = 8'h1F;
   localparam logic [9:0] ADDR_LOOP_CTRL = {IDX_LOOP_CTRL, 2'b00};
   localparam logic [9:0] ADDR_BW_CTRL = {IDX_BW_CTRL, 2'b00};
   localparam logic [9:0] ADDR_MULT = {IDX_MULT, 2'b00};
   localparam logic [9:0] ADDR_TOL = {IDX_TOL, 2'b00};
   // Control register fields
   localparam int BIT_IRQ_EN = 7;
   localparam int BIT_CHANGE = 6;
   localparam int BIT_POWER = 5;
   localparam int BIT_BCS = 4;
   localparam logic [3:0] CTRL_UNUSED = 4'hF;
   // Bandwidth register fields
   localparam int BIT_AUTO = 7;
   localparam int BIT_LOCK = 6;
   localparam int BIT_TRACK = 5;
   // Reset values
   localparam logic RST_POWER = 1'b1;
   localparam logic [7:0] RST_MULT = 8'h66;
   localparam logic [15:0] RST_TOL = 16'h4321;
   // Lock detector window in reference edges, and centre frequency
   localparam logic [7:0] REF_WINDOW = 8'h10;
   localparam logic [31:0] NOM_CENTER_HZ = 32'h004B_0000;
   localparam logic [1:0] SWITCH_EDGES = 2'h3;
   // Tolerance windows, each a count difference
   typedef struct packed {
      logic [3:0] unlock;
      logic [3:0] lock;
      logic [3:0] untrack;
      logic [3:0] track;
   } tol_t;
   typedef enum logic {SEL_IDLE, SEL_WAIT} sel_state_t;
endpackage
`default_nettype wire

//--- src/pll_mode_and_base_clock_select.sv
// Purpose: Loop control, lock detection and glitch-free base clock selection
// Assumes: crystal_clock and vco_clock are sampled levels synchronous to pclk
// Notes: Zero-wait free answer is one wait state; all outputs registered
//
// Summary of operation
// - VCO edges pass a modulo-N divider to form the feedback clock.
// - VCO centre frequency equals L times 4.9152 MHz.
// - Phase detector pulses up or down by which edge leads.
// - Lock detector compares feedback and reference rates for mode and lock.
// - Acquisition mode reads tracking select as zero.
// - Tracking whenever not acquiring or tracking select is one.
// - Automatic mode lets the detector switch filter modes itself.
// - Automatic: tracking select read-only, set inside and cleared outside windows.
// - Automatic: settled flag read-only, set inside lock and cleared outside unlock.
// - Automatic: settled toggle raises interrupt when enabled.
// - Manual: software writes tracking select directly.
// - Manual: settled flag disabled and no interrupt.
// - Multiplier register: N in upper nibble, L in lower nibble.
// - N of zero acts as one.
// - L of zero disables loop and forces crystal source.
// - Source change waits three crystal edges, and three VCO edges while the loop is on; output held.
// - Selected source divided by two for the base clock.
// - VCO source refused while loop is off.
// - Loop off refused while VCO selected; no power change with select change.
// - Change flag set on settled toggle, zero in manual, cleared by read.
// - Reset and stop clear base clock select.
`default_nettype none
module pll_mode_and_base_clock_select
   import pll_ctrl_pkg::*;
(
   input wire logic pclk, // Bus clock
   input wire logic presetn, // Async reset, low
   input wire logic clk_en, // Freezes all state when low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [9:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped
   input wire logic crystal_clock, // Sampled crystal clock
   input wire logic vco_clock, // Sampled VCO clock
   input wire logic stop_request, // Stop mode entry
   output logic final_reference_clock, // Buffered reference
   output logic vco_feedback_clock, // Divider wrap pulse
   output logic pump_up, // Correction: speed up
   output logic pump_down, // Correction: slow down
   output logic filter_tracking_mode, // High in tracking mode
   output logic loop_enable, // Loop running
   output logic [31:0] vco_center_hz, // Centre-of-range frequency
   output logic base_clock_out, // Base clock
   output logic loop_irq // Interrupt request
);
   logic loop_irq_enable, loop_change_flag, loop_power_on, base_clock_select;
   logic bw_auto, frequency_settled_flag, filter_tracking_select;
   logic [7:0] mult;
   tol_t tol;
   logic xtal_q, vco_q, xtal_rise, vco_rise;
   logic [3:0] div_cnt, n_eff;
   logic [7:0] ref_cnt, fb_cnt, diff;
   logic lock_toggle, window_end;
   sel_state_t sel_state;
   logic src_sel, eff_sel;
   logic [1:0] xtal_seen, vco_seen;
   logic acc, wr, rd_ctrl, mapped;
   logic [31:0] next_rdata;
   logic next_power, next_bcs, power_ch, bcs_ch;

   // Distance between measured and expected feedback count
   function automatic logic [7:0] abs_diff(input logic [7:0] a, input logic [7:0] b);
      abs_diff = (a > b) ? 8'(a - b) : 8'(b - a);
   endfunction

   // Bus decode
   assign acc = psel && penable && pready;
   assign wr = acc && pwrite;
   assign rd_ctrl = acc && !pwrite && (paddr == ADDR_LOOP_CTRL);
   assign mapped = (paddr == ADDR_LOOP_CTRL) || (paddr == ADDR_BW_CTRL) ||
                   (paddr == ADDR_MULT) || (paddr == ADDR_TOL);
   assign n_eff = (mult[7:4] == 4'h0) ? 4'h1 : mult[7:4];
   assign xtal_rise = crystal_clock && !xtal_q;
   assign vco_rise = vco_clock && !vco_q && loop_enable;
   assign window_end = xtal_rise && (ref_cnt == REF_WINDOW - 8'h01);
   assign diff = abs_diff(fb_cnt, REF_WINDOW);
   assign eff_sel = base_clock_select && (mult[3:0] != 4'h0);

   // Control write protection between power and source select
   always_comb begin
      power_ch = pwdata[BIT_POWER] != loop_power_on;
      bcs_ch = pwdata[BIT_BCS] != base_clock_select;
      next_power = (base_clock_select || bcs_ch) ? loop_power_on : pwdata[BIT_POWER];
      next_bcs = power_ch ? base_clock_select :
                 (pwdata[BIT_BCS] && loop_power_on && (mult[3:0] != 4'h0));
   end

   // Read mux; manual mode hides enable, flag and lock
   always_comb begin
      next_rdata = 32'h0000_0000;
      case (paddr)
         ADDR_LOOP_CTRL: next_rdata[7:0] = {loop_irq_enable && bw_auto, loop_change_flag && bw_auto,
                                            loop_power_on, base_clock_select, CTRL_UNUSED};
         ADDR_BW_CTRL: next_rdata[7:0] = {bw_auto, frequency_settled_flag && bw_auto, filter_tracking_select, 5'h00};
         ADDR_MULT: next_rdata[7:0] = mult;
         ADDR_TOL: next_rdata[15:0] = tol;
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   // APB answer: one wait state so read data comes from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (clk_en) begin
         pready <= psel && penable && !pready;
         if (psel && penable && !pready) begin
            prdata <= pwrite ? 32'h0000_0000 : next_rdata;
            pslverr <= !mapped;
         end else begin
            pslverr <= 1'b0;
         end
      end
   end

   // Loop control register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loop_irq_enable <= 1'b0;
         loop_power_on <= RST_POWER;
         base_clock_select <= 1'b0;
      end else if (clk_en) begin
         if (stop_request) begin
            base_clock_select <= 1'b0;
         end else if (wr && paddr == ADDR_LOOP_CTRL) begin
            if (bw_auto) begin
               loop_irq_enable <= pwdata[BIT_IRQ_EN];
            end
            loop_power_on <= next_power;
            base_clock_select <= next_bcs;
         end
         if (wr && paddr == ADDR_LOOP_CTRL && stop_request && !base_clock_select) begin
            loop_power_on <= pwdata[BIT_POWER];
         end
      end
   end

   // Change flag: set wins over the clearing read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loop_change_flag <= 1'b0;
      end else if (clk_en) begin
         if (lock_toggle) begin
            loop_change_flag <= 1'b1;
         end else if (rd_ctrl || !bw_auto) begin
            loop_change_flag <= 1'b0;
         end
      end
   end

   // Mode, multiplier and tolerance registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bw_auto <= 1'b0;
         mult <= RST_MULT;
         tol <= RST_TOL;
      end else if (clk_en && wr) begin
         if (paddr == ADDR_BW_CTRL) begin
            bw_auto <= pwdata[BIT_AUTO];
         end
         if (paddr == ADDR_MULT) begin
            mult <= pwdata[7:0];
         end
         if (paddr == ADDR_TOL) begin
            tol <= pwdata[15:0];
         end
      end
   end

   // Edge samplers, feedback divider and phase detector
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xtal_q <= 1'b0;
         vco_q <= 1'b0;
         div_cnt <= 4'h0;
         vco_feedback_clock <= 1'b0;
         final_reference_clock <= 1'b0;
         pump_up <= 1'b0;
         pump_down <= 1'b0;
      end else if (clk_en) begin
         xtal_q <= crystal_clock;
         vco_q <= vco_clock;
         final_reference_clock <= crystal_clock;
         // At or above the end count, so a smaller N never waits for a full wrap
         vco_feedback_clock <= vco_rise && (div_cnt >= n_eff - 4'h1);
         if (!loop_enable) begin
            div_cnt <= 4'h0;
         end else if (vco_rise) begin
            div_cnt <= (div_cnt >= n_eff - 4'h1) ? 4'h0 : 4'(div_cnt + 4'h1);
         end
         // Pulse lasts from leading edge until lagging edge
         if (!loop_enable || (pump_up && vco_feedback_clock) || (pump_down && xtal_rise)) begin
            pump_up <= 1'b0;
            pump_down <= 1'b0;
         end else if (xtal_rise && !vco_feedback_clock && !pump_down) begin
            pump_up <= 1'b1;
         end else if (vco_feedback_clock && !xtal_rise && !pump_up) begin
            pump_down <= 1'b1;
         end
      end
   end

   // Lock detector: feedback edges over a fixed reference window
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_cnt <= 8'h00;
         fb_cnt <= 8'h00;
         frequency_settled_flag <= 1'b0;
         filter_tracking_select <= 1'b0;
         lock_toggle <= 1'b0;
      end else if (clk_en) begin
         lock_toggle <= 1'b0;
         if (!loop_enable) begin
            ref_cnt <= 8'h00;
            fb_cnt <= 8'h00;
         end else if (window_end) begin
            ref_cnt <= 8'h00;
            fb_cnt <= 8'h00;
         end else begin
            ref_cnt <= xtal_rise ? 8'(ref_cnt + 8'h01) : ref_cnt;
            fb_cnt <= vco_feedback_clock ? 8'(fb_cnt + 8'h01) : fb_cnt;
         end
         if (!bw_auto) begin
            frequency_settled_flag <= 1'b0;
            if (wr && paddr == ADDR_BW_CTRL) begin
               filter_tracking_select <= pwdata[BIT_TRACK];
            end
         end else if (!loop_enable) begin
            lock_toggle <= frequency_settled_flag;
            frequency_settled_flag <= 1'b0;
            filter_tracking_select <= 1'b0;
         end else if (window_end) begin
            if (diff <= {4'h0, tol.track}) begin
               filter_tracking_select <= 1'b1;
            end else if (diff > {4'h0, tol.untrack}) begin
               filter_tracking_select <= 1'b0;
            end
            if (!frequency_settled_flag && diff <= {4'h0, tol.lock}) begin
               frequency_settled_flag <= 1'b1;
               lock_toggle <= 1'b1;
            end else if (frequency_settled_flag && diff > {4'h0, tol.unlock}) begin
               frequency_settled_flag <= 1'b0;
               lock_toggle <= 1'b1;
            end
         end
      end
   end

   // Loop status outputs and interrupt
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loop_enable <= 1'b0;
         filter_tracking_mode <= 1'b0;
         vco_center_hz <= 32'h0000_0000;
         loop_irq <= 1'b0;
      end else if (clk_en) begin
         loop_enable <= loop_power_on && (mult[3:0] != 4'h0);
         filter_tracking_mode <= filter_tracking_select;
         vco_center_hz <= 32'(NOM_CENTER_HZ * {28'h0, mult[3:0]});
         loop_irq <= bw_auto && loop_irq_enable && loop_change_flag;
      end
   end

   // Glitch-free switch; output frozen while both clocks are counted
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_state <= SEL_IDLE;
         src_sel <= 1'b0;
         xtal_seen <= 2'h0;
         vco_seen <= 2'h0;
         base_clock_out <= 1'b0;
      end else if (clk_en) begin
         case (sel_state)
            SEL_IDLE: begin
               xtal_seen <= 2'h0;
               vco_seen <= 2'h0;
               if (eff_sel != src_sel) begin
                  sel_state <= SEL_WAIT;
               end else if (src_sel ? vco_rise : xtal_rise) begin
                  base_clock_out <= !base_clock_out;
               end
            end
            SEL_WAIT: begin
               if (xtal_rise && xtal_seen != SWITCH_EDGES) begin
                  xtal_seen <= 2'(xtal_seen + 2'h1);
               end
               if (vco_rise && vco_seen != SWITCH_EDGES) begin
                  vco_seen <= 2'(vco_seen + 2'h1);
               end
               // A stopped VCO cannot hold the switch forever
               if (xtal_seen == SWITCH_EDGES && (vco_seen == SWITCH_EDGES || !loop_enable)) begin
                  src_sel <= eff_sel;
                  sel_state <= SEL_IDLE;
               end
            end
            default: sel_state <= SEL_IDLE;
         endcase
      end
   end

   // Checks
   property p_divider;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && loop_enable && vco_rise && div_cnt == n_eff - 4'h1) |=> vco_feedback_clock;
   endproperty
   a_divider: assert property (p_divider) else $error("feedback pulse missing");
   property p_n_zero;
      @(posedge pclk) disable iff (!presetn)
      (mult[7:4] == 4'h0) |-> (n_eff == 4'h1);
   endproperty
   a_n_zero: assert property (p_n_zero) else $error("N zero not one");
   property p_l_zero;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && mult[3:0] == 4'h0) |=> !loop_enable && !eff_sel;
   endproperty
   a_l_zero: assert property (p_l_zero) else $error("L zero left loop on");
   property p_vco_needs_power;
      @(posedge pclk) disable iff (!presetn)
      base_clock_select |-> loop_power_on;
   endproperty
   a_vco_needs_power: assert property (p_vco_needs_power) else $error("VCO selected with loop off");
   property p_no_power_off;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && base_clock_select && wr && paddr == ADDR_LOOP_CTRL) |=> loop_power_on;
   endproperty
   a_no_power_off: assert property (p_no_power_off) else $error("loop cleared while VCO selected");
   property p_manual_quiet;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && !bw_auto) [*2] |=> !frequency_settled_flag && !loop_irq;
   endproperty
   a_manual_quiet: assert property (p_manual_quiet) else $error("manual mode lock or irq");
   property p_read_clears;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && rd_ctrl && !lock_toggle) |=> !loop_change_flag;
   endproperty
   a_read_clears: assert property (p_read_clears) else $error("flag survived read");
   property p_stop_clears;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && stop_request) |=> !base_clock_select;
   endproperty
   a_stop_clears: assert property (p_stop_clears) else $error("stop left VCO selected");
   property p_hold;
      @(posedge pclk) disable iff (!presetn)
      (sel_state == SEL_WAIT) |=> $stable(base_clock_out);
   endproperty
   a_hold: assert property (p_hold) else $error("base clock moved in transition");
   property p_pump_exclusive;
      @(posedge pclk) disable iff (!presetn)
      !(pump_up && pump_down);
   endproperty
   a_pump_exclusive: assert property (p_pump_exclusive) else $error("both pump directions active");
   c_lock: cover property (@(posedge pclk) disable iff (!presetn) $rose(frequency_settled_flag));
   c_switch: cover property (@(posedge pclk) disable iff (!presetn) $rose(src_sel));
   c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(loop_irq));
   c_pump_down: cover property (@(posedge pclk) disable iff (!presetn) $rose(pump_down));
   c_tracking: cover property (@(posedge pclk) disable iff (!presetn) $rose(filter_tracking_mode));
endmodule
`default_nettype wire

//--- verification/clock_source_model.sv
// Purpose: Crystal and VCO sources seen by the loop controller
// Assumes: Both clocks are levels sampled on pclk, slower than pclk/2
// Notes: VCO stands low while the loop is off, like an unpowered oscillator
`default_nettype none
module clock_source_model (
   input wire logic pclk, // Bus clock
   input wire logic presetn, // Async reset, low
   input wire logic loop_enable, // Oscillator powered
   input wire logic [3:0] vco_half, // VCO half period in pclk cycles
   output logic crystal_clock, // Crystal level
   output logic vco_clock // VCO level
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] xcnt;
   logic [3:0] vcnt;
   // Crystal runs free with a half period of four bus cycles
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xcnt <= 4'h0;
         crystal_clock <= 1'b0;
      end else if (xcnt == 4'h3) begin
         xcnt <= 4'h0;
         crystal_clock <= ~crystal_clock;
      end else begin
         xcnt <= xcnt + 4'h1;
      end
   end
   // VCO rate is set by the bench to hit or miss the lock window
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn || !loop_enable) begin
         vcnt <= 4'h0;
         vco_clock <= 1'b0;
      end else if (vcnt >= vco_half - 4'h1) begin
         vcnt <= 4'h0;
         vco_clock <= ~vco_clock;
      end else begin
         vcnt <= vcnt + 4'h1;
      end
   end
endmodule
`default_nettype wire

//--- verification/pll_mode_and_base_clock_select_bench.sv
// Purpose: Self-checking bench for loop control and base clock selection
// Assumes: One wait state on every APB access
// Notes: Rates are measured in bus cycles after aligning on an edge
`default_nettype none
module pll_mode_and_base_clock_select_bench import pll_ctrl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [9:0] paddr = 10'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic stop_request = 1'b0;
   logic [3:0] vco_half = 4'h2;
   logic [31:0] prdata, vco_center_hz;
   logic pready, pslverr, crystal_clock, vco_clock, vco_feedback_clock;
   logic filter_tracking_mode, loop_enable, base_clock_out, loop_irq;
   logic final_reference_clock, pump_up, pump_down;
   logic clk_en = 1'b1;
   int n_errors = 0;
   int n_compared = 0;
   always #5 pclk = ~pclk;
   pll_mode_and_base_clock_select u_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .crystal_clock(crystal_clock), .vco_clock(vco_clock), .stop_request(stop_request),
      .final_reference_clock(final_reference_clock), .vco_feedback_clock(vco_feedback_clock),
      .pump_up(pump_up), .pump_down(pump_down),
      .filter_tracking_mode(filter_tracking_mode), .loop_enable(loop_enable), .vco_center_hz(vco_center_hz),
      .base_clock_out(base_clock_out), .loop_irq(loop_irq));
   clock_source_model u_src (.pclk(pclk), .presetn(presetn), .loop_enable(loop_enable), .vco_half(vco_half),
      .crystal_clock(crystal_clock), .vco_clock(vco_clock));
   // Verdict and end of run
   task automatic test_done();
      if (n_errors == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   // One APB transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d, output logic [31:0] r,
      output logic e);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      r = prdata;
      e = pslverr;
      chk("pready", 32'h1, {31'h0, pready});
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rd(input logic [9:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk("rdata", exp, r);
   endtask
   // Align on one event, then count events over a span of bus cycles
   task automatic cnt(input logic base, input int span, input int exp);
      int n;
      logic last;
      n = 0;
      last = base_clock_out;
      while (n < 200 && (base ? base_clock_out === last : vco_feedback_clock !== 1'b1)) begin
         last = base_clock_out;
         @(posedge pclk);
         n++;
      end
      n = 0;
      last = base_clock_out;
      repeat (span) begin
         @(posedge pclk);
         n += base ? int'(base_clock_out !== last) : int'(vco_feedback_clock === 1'b1);
         last = base_clock_out;
      end
      chk("edge count", exp, n);
   endtask
   // Pump direction and reference copy over a span; only the correcting direction may be pumped
   task automatic t_phase(input logic fb_fast);
      int n_up;
      int n_dn;
      int n_ref;
      logic prev;
      n_up = 0;
      n_dn = 0;
      n_ref = 0;
      @(posedge pclk);
      prev = crystal_clock;
      repeat (160) begin
         @(posedge pclk);
         n_up += int'(pump_up === 1'b1);
         n_dn += int'(pump_down === 1'b1);
         n_ref += int'(final_reference_clock !== prev);
         prev = crystal_clock;
      end
      chk("reference copy", 32'h0, n_ref);
      chk("pump wrong way", 32'h0, fb_fast ? n_up : n_dn);
      chk("pump right way", 32'h1, {31'h0, (fb_fast ? n_dn : n_up) > 0});
   endtask
   task automatic t_reset();
      logic [31:0] r;
      logic e;
      rd(ADDR_LOOP_CTRL, 32'h2F);
      rd(ADDR_BW_CTRL, 32'h00);
      rd(ADDR_MULT, 32'h66);
      rd(ADDR_TOL, 32'h4321);
      chk("center", 32'h01C2_0000, vco_center_hz);
      apb(1'b0, 10'h000, 32'h0, r, e);
      chk("slverr", 32'h1, {31'h0, e});
      chk("unmapped", 32'h0, r);
   endtask
   task automatic t_mult();
      wr(ADDR_MULT, 32'h20);
      rd(ADDR_MULT, 32'h20);
      @(posedge pclk);
      chk("loop off", 32'h0, {31'h0, loop_enable});
      wr(ADDR_LOOP_CTRL, 32'h30);
      rd(ADDR_LOOP_CTRL, 32'h2F);
      wr(ADDR_MULT, 32'h27);
      repeat (2) @(posedge pclk);
      chk("center", 32'h020D_0000, vco_center_hz);
      chk("loop on", 32'h1, {31'h0, loop_enable});
   endtask
   // Manual bring-up as software is obliged to do it
   task automatic t_manual();
      wr(ADDR_LOOP_CTRL, 32'h00);
      wr(ADDR_BW_CTRL, 32'h00);
      wr(ADDR_LOOP_CTRL, 32'h20);
      repeat (60) @(posedge pclk);
      wr(ADDR_BW_CTRL, 32'h20);
      rd(ADDR_BW_CTRL, 32'h20);
      chk("tracking", 32'h1, {31'h0, filter_tracking_mode});
      wr(ADDR_BW_CTRL, 32'h00);
      repeat (2) @(posedge pclk);
      chk("acquire", 32'h0, {31'h0, filter_tracking_mode});
      wr(ADDR_BW_CTRL, 32'h20);
      repeat (60) @(posedge pclk);
      wr(ADDR_LOOP_CTRL, 32'hB0);
      rd(ADDR_LOOP_CTRL, 32'h3F);
      wr(ADDR_LOOP_CTRL, 32'h00);
      rd(ADDR_LOOP_CTRL, 32'h3F);
      wr(ADDR_LOOP_CTRL, 32'h10);
      rd(ADDR_LOOP_CTRL, 32'h3F);
      chk("irq", 32'h0, {31'h0, loop_irq});
   endtask
   task automatic t_switch();
      int n;
      logic last;
      repeat (20) @(posedge pclk);
      cnt(1'b1, 160, 40);
      stop_request <= 1'b1;
      @(posedge pclk);
      stop_request <= 1'b0;
      rd(ADDR_LOOP_CTRL, 32'h2F);
      repeat (40) @(posedge pclk);
      cnt(1'b1, 160, 20);
      // Clock enable low must freeze the divided output
      clk_en <= 1'b0;
      @(posedge pclk);
      last = base_clock_out;
      n = 0;
      repeat (40) begin
         @(posedge pclk);
         n += int'(base_clock_out !== last);
      end
      chk("frozen", 32'h0, n);
      clk_en <= 1'b1;
      wr(ADDR_LOOP_CTRL, 32'h00);
      wr(ADDR_LOOP_CTRL, 32'h10);
      rd(ADDR_LOOP_CTRL, 32'h0F);
      wr(ADDR_LOOP_CTRL, 32'h30);
      rd(ADDR_LOOP_CTRL, 32'h0F);
      wr(ADDR_LOOP_CTRL, 32'h20);
   endtask
   task automatic t_divider();
      wr(ADDR_MULT, 32'h37);
      cnt(1'b0, 240, 20);
      wr(ADDR_MULT, 32'h07);
      cnt(1'b0, 240, 60);
      t_phase(1'b1);
      wr(ADDR_MULT, 32'h17);
      cnt(1'b0, 240, 60);
   endtask
   // Feedback rate equals reference rate with N of two, then falls away
   task automatic t_auto();
      wr(ADDR_MULT, 32'h27);
      wr(ADDR_BW_CTRL, 32'h80);
      wr(ADDR_LOOP_CTRL, 32'hA0);
      repeat (400) @(posedge pclk);
      rd(ADDR_BW_CTRL, 32'hE0);
      chk("tracking", 32'h1, {31'h0, filter_tracking_mode});
      chk("irq", 32'h1, {31'h0, loop_irq});
      rd(ADDR_LOOP_CTRL, 32'hEF);
      rd(ADDR_LOOP_CTRL, 32'hAF);
      chk("irq", 32'h0, {31'h0, loop_irq});
      vco_half <= 4'h4;
      repeat (400) @(posedge pclk);
      t_phase(1'b0);
      wr(ADDR_BW_CTRL, 32'hA0);
      rd(ADDR_BW_CTRL, 32'h80);
      chk("acquire", 32'h0, {31'h0, filter_tracking_mode});
      chk("irq", 32'h1, {31'h0, loop_irq});
      wr(ADDR_BW_CTRL, 32'h00);
      rd(ADDR_LOOP_CTRL, 32'h2F);
      chk("irq", 32'h0, {31'h0, loop_irq});
   endtask
   // Watchdog well beyond the few thousand cycles the tests need
   initial begin
      repeat (20000) @(posedge pclk);
      n_errors++;
      test_done();
   end
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_mult();
      t_manual();
      t_switch();
      t_divider();
      t_auto();
      test_done();
   end
endmodule
`default_nettype wire
